// File: design/kns_pkg.sv
// Purpose: Constants and types for the keyboard NMI status block
// Assumes: 8-bit registers on a 32-bit AXI4-Lite slave, word index times four
// Notes: Index constants times four give the byte addresses
package kns_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] IDX_SCAN = 8'h09;
   localparam logic [7:0] IDX_RETURN_HIGH = 8'h0B;
   localparam logic [7:0] IDX_NMI = 8'h0C;
   localparam logic [7:0] IDX_ISTAT = 8'h20;
   localparam logic [7:0] IDX_IMASK = 8'h21;
   localparam logic [7:0] ADDR_SCAN = IDX_SCAN << 2;
   localparam logic [7:0] ADDR_RETURN_HIGH = IDX_RETURN_HIGH << 2;
   localparam logic [7:0] ADDR_NMI = IDX_NMI << 2;
   localparam logic [7:0] ADDR_ISTAT = IDX_ISTAT << 2;
   localparam logic [7:0] ADDR_IMASK = IDX_IMASK << 2;
   localparam int NMI_FLAG_LSB = 5;
   localparam int NMI_EN_LSB = 2;
   localparam int NMI_SHIFT4_BIT = 0;
   localparam logic [7:0] SCAN_RST = 8'h00;
   localparam logic [2:0] NMI_RST = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Cause and enable bit 2 = key press, 1 = scan timeout, 0 = diagnostics
   typedef struct packed {
      logic [2:0] flag;
      logic [2:0] en;
      logic rsvd;
      logic shift4;
   } kns_nmi_t;
   typedef enum logic {
      RS_IDLE = 1'b0,
      RS_DATA = 1'b1
   } kns_rst_t;
endpackage

// File: design/kns_keyboard_nmi.sv
// Purpose: Keyboard shift status, scan pin control and NMI cause logic
// Assumes: Pins synchronous to core_clk; events are one-cycle pulses
// Notes: Key press is edge-detected; a set beats a same-cycle one-write clear
`timescale 1ns/1ps
`default_nettype none
module kns_keyboard_nmi
   import kns_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [3:0] shift_switch_inputs,
   input wire logic fifth_shift_input,
   input wire logic [3:0] upper_return_inputs,
   input wire logic [7:0] lower_return_inputs,
   input wire logic scan_done,
   input wire logic scan_timeout,
   input wire logic system_control_port_b_diag,
   output logic [7:0] scan_pin_o,
   output logic [7:0] scan_pin_oe,
   output logic scan_restart,
   output logic nmi,
   output logic irq
);
   logic aw_got_ff, w_got_ff, wstrb0_ff, key_prev_ff;
   logic [7:0] aw_addr_ff, wd_ff;
   logic [7:0] scan_ctrl_ff;
   logic [2:0] flag_ff, en_ff, istat_ff, imask_ff;
   kns_rst_t rd_state_ff;
   logic wr_go, wr_ok, wr_nmi, wr_scan, wr_istat, wr_imask, wr_map;
   logic any_key, scan_idle, key_ev;
   logic [2:0] ev, en_nxt, nxt_flag, nxt_istat, w1c;
   logic [7:0] ar_word;
   logic [31:0] rd_val;
   logic rd_err;
   kns_nmi_t nmi_view;

   // Write side: address and data latched in either order
   assign wr_go = aw_got_ff & w_got_ff & ~s_axi_bvalid;
   assign wr_ok = wr_go & wstrb0_ff;
   assign wr_map = (aw_addr_ff == ADDR_SCAN) | (aw_addr_ff == ADDR_NMI) |
                   (aw_addr_ff == ADDR_ISTAT) | (aw_addr_ff == ADDR_IMASK) |
                   (aw_addr_ff == ADDR_RETURN_HIGH);
   assign wr_scan = wr_ok & (aw_addr_ff == ADDR_SCAN);
   assign wr_nmi = wr_ok & (aw_addr_ff == ADDR_NMI);
   assign wr_istat = wr_ok & (aw_addr_ff == ADDR_ISTAT);
   assign wr_imask = wr_ok & (aw_addr_ff == ADDR_IMASK);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b1;
         aw_got_ff <= 1'b0;
         aw_addr_ff <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         aw_got_ff <= 1'b1;
         aw_addr_ff <= {s_axi_awaddr[7:2], 2'b00};
      end else begin
         if (wr_go) aw_got_ff <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_wready <= 1'b1;
         w_got_ff <= 1'b0;
         wd_ff <= 8'h00;
         wstrb0_ff <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         w_got_ff <= 1'b1;
         wd_ff <= s_axi_wdata[7:0];
         wstrb0_ff <= s_axi_wstrb[0];
      end else begin
         if (wr_go) w_got_ff <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) s_axi_wready <= 1'b1;
      end
   end

   // Read-only and unmapped writes get SLVERR, nothing changes
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (wr_map && aw_addr_ff != ADDR_RETURN_HIGH) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Key detection only while every scan line is held low
   assign any_key = ~&{upper_return_inputs, lower_return_inputs};
   assign scan_idle = &scan_ctrl_ff;
   assign key_ev = scan_idle & any_key & ~key_prev_ff;
   assign ev = {key_ev, scan_timeout, system_control_port_b_diag};

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) key_prev_ff <= 1'b0;
      else key_prev_ff <= any_key;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         scan_ctrl_ff <= SCAN_RST;
         scan_pin_oe <= SCAN_RST;
         scan_pin_o <= 8'h00;
      end else begin
         scan_pin_o <= 8'h00;
         if (wr_scan) begin
            scan_ctrl_ff <= wd_ff;
            scan_pin_oe <= wd_ff;
         end else if (scan_done && !any_key) begin
            scan_ctrl_ff <= 8'hFF;
            scan_pin_oe <= 8'hFF;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) scan_restart <= 1'b0;
      else scan_restart <= key_ev;
   end

   // Set wins over a one-write; a zero enable write still forces clear
   assign en_nxt = wr_nmi ? wd_ff[NMI_FLAG_LSB-1:NMI_EN_LSB] : en_ff;
   assign w1c = wr_nmi ? wd_ff[7:NMI_FLAG_LSB] : 3'h0;
   assign nxt_flag = ((flag_ff & ~w1c) | ev) & en_nxt;
   assign nxt_istat = wr_istat ? ((istat_ff & ~wd_ff[2:0]) | ev) : (istat_ff | ev);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_ff <= NMI_RST;
         en_ff <= NMI_RST;
      end else begin
         flag_ff <= nxt_flag;
         en_ff <= en_nxt;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) nmi <= 1'b0;
      else nmi <= |(nxt_flag & en_nxt);
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         istat_ff <= 3'h0;
         imask_ff <= 3'h0;
         irq <= 1'b0;
      end else begin
         istat_ff <= nxt_istat;
         if (wr_imask) imask_ff <= wd_ff[2:0];
         irq <= |(nxt_istat & (wr_imask ? wd_ff[2:0] : imask_ff));
      end
   end

   // Read side
   assign ar_word = {s_axi_araddr[7:2], 2'b00};
   always_comb begin
      nmi_view.flag = flag_ff;
      nmi_view.en = en_ff;
      nmi_view.rsvd = 1'b0;
      nmi_view.shift4 = fifth_shift_input;
      rd_err = 1'b0;
      case (ar_word)
         ADDR_SCAN: rd_val = {24'h00_0000, scan_ctrl_ff};
         ADDR_RETURN_HIGH: begin
            rd_val = {24'h00_0000, shift_switch_inputs, upper_return_inputs};
         end
         ADDR_NMI: rd_val = {24'h00_0000, nmi_view};
         ADDR_ISTAT: rd_val = {29'h0000_0000, istat_ff};
         ADDR_IMASK: rd_val = {29'h0000_0000, imask_ff};
         default: begin
            rd_val = 32'h0000_0000;
            rd_err = 1'b1;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_state_ff <= RS_IDLE;
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         case (rd_state_ff)
            RS_IDLE: begin
               if (s_axi_arvalid) begin
                  rd_state_ff <= RS_DATA;
                  s_axi_arready <= 1'b0;
                  s_axi_rvalid <= 1'b1;
                  s_axi_rdata <= rd_val;
                  s_axi_rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
               end
            end
            RS_DATA: begin
               if (s_axi_rready) begin
                  rd_state_ff <= RS_IDLE;
                  s_axi_arready <= 1'b1;
                  s_axi_rvalid <= 1'b0;
               end
            end
            default: rd_state_ff <= RS_IDLE;
         endcase
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence s_rd_at(logic [7:0] a);
      s_axi_arvalid && s_axi_arready && ar_word == a;
   endsequence

   chk_ret_high_read: assert property (s_rd_at(ADDR_RETURN_HIGH) |=>
      s_axi_rdata[7:0] == $past({shift_switch_inputs, upper_return_inputs}))
      else $error("upper return status read wrong");
   chk_nmi_read_bits: assert property (s_rd_at(ADDR_NMI) |=>
      s_axi_rdata[1:0] == {1'b0, $past(fifth_shift_input)} && s_axi_rvalid)
      else $error("nmi register low bits wrong");
   chk_key_flag_set: assert property (key_ev && en_nxt[2] |=> flag_ff[2] && nmi)
      else $error("key press cause not set");
   chk_scan_flag_set: assert property (scan_timeout && en_nxt[1] |=>
      flag_ff[1] && nmi)
      else $error("scan timeout cause not set");
   chk_diag_flag_set: assert property (system_control_port_b_diag && en_nxt[0] |=>
      flag_ff[0])
      else $error("diagnostics cause not set");
   chk_w1c_clear: assert property (wr_nmi && wd_ff[7] && !key_ev |=> !flag_ff[2])
      else $error("cause not cleared by one write");
   chk_key_gate: assert property ($rose(flag_ff[2]) |-> $past(en_nxt[2]))
      else $error("key cause set while disabled");
   chk_scan_gate: assert property ($rose(flag_ff[1]) |-> $past(en_nxt[1]))
      else $error("scan cause set while disabled");
   chk_diag_gate: assert property ($rose(flag_ff[0]) |-> $past(en_nxt[0]))
      else $error("diag cause set while disabled");
   chk_en_zero_clear: assert property (wr_nmi && wd_ff[4:2] == 3'h0 |=>
      flag_ff == 3'h0 && !nmi)
      else $error("zero enable did not clear causes");
   chk_idle_scan: assert property (scan_done && !any_key && !wr_scan |=>
      scan_pin_oe == 8'hFF)
      else $error("idle scan did not drive all lines");
   chk_scan_pins: assert property (wr_scan |=>
      scan_pin_oe == $past(wd_ff) && scan_pin_o == 8'h00)
      else $error("scan pin enables not updated");
   chk_nmi_level: assert property (|(flag_ff & en_ff) |-> nmi)
      else $error("nmi low with enabled cause");
endmodule
`default_nettype wire

// File: tb/kns_matrix_model.sv
// Purpose: Key switch matrix seen from the scan and return pins
// Assumes: One key, return lines pulled up
// Notes: A released line reads high through its pull-up
`timescale 1ns/1ps
`default_nettype none
module kns_matrix_model (
   input wire logic [7:0] scan_pin_o,
   input wire logic [7:0] scan_pin_oe,
   input wire logic [2:0] key_scan,
   input wire logic [2:0] key_ret,
   input wire logic key_down,
   output logic [7:0] lower_return_inputs
);
   // Closed key pulls its return low only while its scan pin sinks
   always_comb begin
      lower_return_inputs = 8'hFF;
      if (key_down && scan_pin_oe[key_scan] && !scan_pin_o[key_scan]) begin
         lower_return_inputs[key_ret] = 1'b0;
      end
   end
endmodule
`default_nettype wire

// File: tb/tb.sv
// Purpose: Self-checking bench for the keyboard NMI status block
// Assumes: Shared AXI4-Lite tasks, events as one-cycle pulses
// Notes: Scanner mode only; serial mode readings are not relied on
`timescale 1ns/1ps
`default_nettype none
module tb
   import kns_pkg::*;
;
   typedef struct packed {
      logic [3:0] shift;
      logic [3:0] up;
      logic f;
      logic [7:0] high;
      logic [7:0] nm;
   } kns_row_t;
   kns_row_t rows[4] = '{{4'hF, 4'hF, 1'b1, 8'hFF, 8'h01}, {4'h0, 4'h0, 1'b0, 8'h00, 8'h00},
      {4'hA, 4'h5, 1'b1, 8'hA5, 8'h01}, {4'h5, 4'hA, 1'b0, 8'h5A, 8'h00}};
   logic core_clk = 0, rst_n = 0, key_down = 0, fifth_shift_input = 1;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, rd_v, lower_return_inputs, scan_pin_o;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, scan_restart, nmi, irq;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF, shift_switch_inputs = 4'hF, upper_return_inputs = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [2:0] ev = 0;
   logic [7:0] scan_pin_oe;
   int err_count = 0, checks = 0;
   kns_keyboard_nmi uut (.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .shift_switch_inputs, .fifth_shift_input,
      .upper_return_inputs, .lower_return_inputs, .scan_done(ev[2]), .scan_timeout(ev[1]),
      .system_control_port_b_diag(ev[0]), .scan_pin_o, .scan_pin_oe, .scan_restart, .nmi, .irq);
   kns_matrix_model mdl (.scan_pin_o, .scan_pin_oe, .key_scan(3'h3), .key_ret(3'h5),
      .key_down, .lower_return_inputs);
   always #50 core_clk = ~core_clk;
   task automatic close_out();
      if (err_count == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tout(input int n);
      if (n >= 50) begin
         err_count++;
         close_out();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         n++;
      end while (s_axi_bvalid !== 1'b1 && n < 50);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      tout(n);
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         n++;
      end while (s_axi_rvalid !== 1'b1 && n < 50);
      rd_v = s_axi_rdata[7:0];
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      tout(n);
   endtask
   task automatic pulse(input logic [2:0] v);
      @(posedge core_clk);
      ev <= v;
      @(posedge core_clk);
      ev <= 3'h0;
   endtask
   initial begin
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(ADDR_NMI);
      chk(rd_v, 8'h01);
      rd(ADDR_SCAN);
      chk(rd_v, 8'h00);
      chk({6'h00, nmi, irq}, 8'h00);
      // Status rows; serial mode is never selected, so the readings count
      foreach (rows[i]) begin
         @(posedge core_clk);
         shift_switch_inputs <= rows[i].shift;
         upper_return_inputs <= rows[i].up;
         fifth_shift_input <= rows[i].f;
         rd(ADDR_RETURN_HIGH);
         chk(rd_v, rows[i].high);
         rd(ADDR_NMI);
         chk(rd_v, rows[i].nm);
      end
      // Return lines back open, else the key edge never comes
      fifth_shift_input <= 1'b1;
      upper_return_inputs <= 4'hF;
      shift_switch_inputs <= 4'hF;
      pulse(3'h1);
      rd(ADDR_NMI);
      chk(rd_v, 8'h01);
      wr(ADDR_NMI, 8'h04);
      pulse(3'h1);
      rd(ADDR_NMI);
      chk(rd_v, 8'h25);
      chk({7'h00, nmi}, 8'h01);
      wr(ADDR_NMI, 8'h24);
      rd(ADDR_NMI);
      chk(rd_v, 8'h05);
      chk({7'h00, nmi}, 8'h00);
      pulse(3'h1);
      wr(ADDR_NMI, 8'h04);
      rd(ADDR_NMI);
      chk(rd_v, 8'h25);
      wr(ADDR_NMI, 8'h00);
      rd(ADDR_NMI);
      chk(rd_v, 8'h01);
      pulse(3'h2);
      rd(ADDR_NMI);
      chk(rd_v, 8'h01);
      wr(ADDR_NMI, 8'h08);
      pulse(3'h2);
      rd(ADDR_NMI);
      chk(rd_v, 8'h49);
      wr(ADDR_NMI, 8'h00);
      rd(ADDR_NMI);
      chk(rd_v, 8'h01);
      // Scan lines sink before the key enable goes on
      wr(ADDR_SCAN, 8'hFF);
      chk(scan_pin_oe, 8'hFF);
      chk(scan_pin_o, 8'h00);
      wr(ADDR_NMI, 8'h10);
      key_down <= 1'b1;
      repeat (2) @(posedge core_clk);
      chk({7'h00, scan_restart}, 8'h01);
      @(posedge core_clk);
      chk({7'h00, scan_restart}, 8'h00);
      rd(ADDR_NMI);
      chk(rd_v, 8'h91);
      chk({7'h00, nmi}, 8'h01);
      wr(ADDR_NMI, 8'h90);
      rd(ADDR_NMI);
      chk(rd_v, 8'h11);
      key_down <= 1'b0;
      wr(ADDR_NMI, 8'h00);
      key_down <= 1'b1;
      rd(ADDR_NMI);
      chk(rd_v, 8'h01);
      key_down <= 1'b0;
      wr(ADDR_SCAN, 8'h00);
      pulse(3'h4);
      rd(ADDR_SCAN);
      chk(rd_v, 8'hFF);
      // Byte lane 0 off: answered OKAY, register untouched
      s_axi_wstrb <= 4'h0;
      wr(ADDR_SCAN, 8'h00);
      chk({6'h00, resp}, {6'h00, RESP_OKAY});
      s_axi_wstrb <= 4'hF;
      rd(ADDR_SCAN);
      chk(rd_v, 8'hFF);
      rd(ADDR_ISTAT);
      chk(rd_v, 8'h07);
      wr(ADDR_IMASK, 8'h01);
      rd(ADDR_IMASK);
      chk(rd_v, 8'h01);
      chk({7'h00, irq}, 8'h01);
      wr(ADDR_ISTAT, 8'h01);
      rd(ADDR_ISTAT);
      chk(rd_v, 8'h06);
      chk({7'h00, irq}, 8'h00);
      rd(8'h40);
      chk({6'h00, resp}, {6'h00, RESP_SLVERR});
      wr(ADDR_RETURN_HIGH, 8'h00);
      chk({6'h00, resp}, {6'h00, RESP_SLVERR});
      // Reset in mid-run drops a pending cause and its enable
      wr(ADDR_NMI, 8'h04);
      pulse(3'h1);
      rst_n <= 1'b0;
      @(posedge core_clk);
      rst_n <= 1'b1;
      rd(ADDR_NMI);
      chk(rd_v, 8'h01);
      rd(ADDR_SCAN);
      chk(rd_v, 8'h00);
      chk({6'h00, nmi, irq}, 8'h00);
      close_out();
   end
endmodule
`default_nettype wire
